// [tdrc_top.sv]
// command interpreter: density mode, descriptor, sense codes and reservation
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tdrc_params.svh"
module tdrc_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // drive condition
    output logic explicit_mode,
    output logic reserved
);
    logic rst_s1;
    logic rst_n_s;
    // ------------------------------------------------------------------------
    // reset release through two flops
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1 <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n_s <= rst_s1;
        end
    end
    // control bits written by firmware, and the owed unit attention flag
    logic hicap;        // higher capacity drive model
    logic at_bot;       // beginning_of_tape_position reached
    logic cart_ok;      // cartridge supports selected density
    logic fmt_match;    // tape format equals selected density
    logic bdr;          // bus device reset pulse
    logic parity_err;   // parity error seen for this command
    logic pending_attn; // unit attention owed
    // command registers
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] den_param;  // density from parameter list
    logic bad_field;        // invalid bit or buffered mode code
    logic [2:0] init_id;
    logic go;
    // results
    logic [7:0] status;
    logic [3:0] sense;
    logic busy;
    logic [7:0] den_sel;    // density in force
    logic [7:0] den_rep;    // density shown by mode sense
    tdrc_pkg::tdrc_state_t state;
    logic apb_wr;
    logic apb_rd;
    logic changed_ev;
    assign apb_wr = psel && penable && pwrite && pready;
    assign apb_rd = psel && penable && !pwrite;
    tdrc_cmd_if cif ();
    assign cif.init_id = init_id;
    assign cif.opcode = opcode;
    assign cif.byte1 = byte1;
    tdrc_reserve u_res (
        .clk(sys_clk),
        .rst_n(rst_n_s),
        .bus_reset(bdr),
        .c(cif)
    );
    // ------------------------------------------------------------------------
    // apb: one wait state, answer in the second access cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pready <= 1'b0;
        end else begin
            // pready pulses for one cycle of each access
            pready <= psel && penable && !pready;
        end
    end
    // control register and strobes
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            hicap <= 1'b0;
            at_bot <= 1'b1;
            cart_ok <= 1'b1;
            fmt_match <= 1'b1;
            bdr <= 1'b0;
            parity_err <= 1'b0;
            changed_ev <= 1'b0;
        end else begin
            bdr <= 1'b0;
            changed_ev <= 1'b0;
            if (apb_wr && paddr == `TDRC_ADDR_CTRL) begin
                hicap <= pwdata[`TDRC_CTRL_HICAP];
                at_bot <= pwdata[`TDRC_CTRL_BOT];
                changed_ev <= pwdata[`TDRC_CTRL_CHANGE];
                bdr <= pwdata[`TDRC_CTRL_BDR];
                parity_err <= pwdata[`TDRC_CTRL_PARITY];
                cart_ok <= pwdata[`TDRC_CTRL_CART];
                fmt_match <= pwdata[`TDRC_CTRL_FMT];
            end
        end
    end
    // command loading; writing the start word launches execution
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            opcode <= 8'h00;
            byte1 <= 8'h00;
            init_id <= 3'h0;
            den_param <= 8'h00;
            bad_field <= 1'b0;
            go <= 1'b0;
        end else begin
            go <= 1'b0;
            if (apb_wr && paddr == `TDRC_ADDR_CMD && !busy) begin
                opcode <= pwdata[7:0];
                byte1 <= pwdata[15:8];
                init_id <= pwdata[18:16];
                go <= 1'b1;
            end
            if (apb_wr && paddr == `TDRC_ADDR_CMD2) begin
                den_param <= pwdata[7:0];
                bad_field <= pwdata[8];
            end
        end
    end
    // ------------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state <= tdrc_pkg::TDRC_IDLE;
        end else begin
            case (state)
                tdrc_pkg::TDRC_IDLE: begin
                    if (go) begin
                        state <= tdrc_pkg::TDRC_EXEC;
                    end
                end
                tdrc_pkg::TDRC_EXEC: begin
                    state <= tdrc_pkg::TDRC_DONE;
                end
                tdrc_pkg::TDRC_DONE: begin
                    state <= tdrc_pkg::TDRC_IDLE;
                end
                default: begin
                    state <= tdrc_pkg::TDRC_IDLE;
                end
            endcase
        end
    end
    assign busy = (state != tdrc_pkg::TDRC_IDLE) || go;
    logic is_rd;
    logic is_wr;
    logic is_ms;
    logic den_legal;
    assign is_rd = (opcode == `TDRC_OP_READ);
    assign is_wr = (opcode == `TDRC_OP_WRITE);
    assign is_ms = (opcode == `TDRC_OP_MODESEL);
    // legal density codes for mode select
    assign den_legal = (den_param == `TDRC_DEN_IMPLICIT) || (den_param == `TDRC_DEN_LOW_A) ||
        (den_param == `TDRC_DEN_LOW_B) || (den_param == `TDRC_DEN_OLD_A) ||
        (den_param == `TDRC_DEN_OLD_B);
    // unit attention: event set wins over the clear of reporting it
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pending_attn <= 1'b1;
        end else if (changed_ev || bdr) begin
            pending_attn <= 1'b1;
        end else if (state == tdrc_pkg::TDRC_EXEC && !cif.blocked && !parity_err) begin
            pending_attn <= 1'b0;
        end
    end
    // ------------------------------------------------------------------------
    // status and sense selection, by priority
    // ------------------------------------------------------------------------
    logic [7:0] next_status;
    logic [3:0] next_sense;
    always_comb begin
        next_status = `TDRC_ST_GOOD;
        next_sense = `TDRC_SK_NONE;
        if (cif.blocked) begin
            next_status = `TDRC_ST_CONFLICT;
        end else if (parity_err) begin
            next_status = `TDRC_ST_CHECK;
            next_sense = `TDRC_SK_HWERR;
        end else if (pending_attn) begin
            next_status = `TDRC_ST_CHECK;
            next_sense = `TDRC_SK_ATTN;
        end else if (is_ms && (bad_field || !den_legal || !at_bot)) begin
            next_status = `TDRC_ST_CHECK;
            next_sense = `TDRC_SK_ILLEGAL;
        end else if (is_wr && hicap && explicit_mode &&
                (den_sel == `TDRC_DEN_LOW_A || den_sel == `TDRC_DEN_LOW_B)) begin
            next_status = `TDRC_ST_CHECK;
            next_sense = `TDRC_SK_ILLEGAL;
        end else if (is_wr && explicit_mode && !cart_ok) begin
            next_status = `TDRC_ST_CHECK;
            next_sense = `TDRC_SK_PROTECT;
        end else if (is_rd && explicit_mode && !fmt_match) begin
            next_status = `TDRC_ST_CHECK;
            next_sense = `TDRC_SK_BLANK;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            status <= `TDRC_ST_GOOD;
            sense <= `TDRC_SK_NONE;
        end else if (state == tdrc_pkg::TDRC_EXEC) begin
            status <= next_status;
            sense <= next_sense;
        end
    end
    // ------------------------------------------------------------------------
    // density mode and reported density
    // ------------------------------------------------------------------------
    logic ok_exec;
    assign ok_exec = (state == tdrc_pkg::TDRC_EXEC) && (next_status == `TDRC_ST_GOOD);
    // a command refused with check condition must not touch the reservation
    assign cif.go = ok_exec;
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            explicit_mode <= 1'b0;
            den_sel <= `TDRC_DEN_IMPLICIT;
            den_rep <= `TDRC_DEN_IMPLICIT;
        end else if (bdr) begin
            // a reset ends the selected mode
            explicit_mode <= 1'b0;
            den_sel <= `TDRC_DEN_IMPLICIT;
            den_rep <= `TDRC_DEN_IMPLICIT;
        end else if (ok_exec) begin
            if (is_ms) begin
                // good mode select moves no media, explicit mode held until a reset
                den_sel <= den_param;
                if (den_param != `TDRC_DEN_IMPLICIT) begin
                    explicit_mode <= 1'b1;
                end
            end else if (is_rd || is_wr) begin
                explicit_mode <= 1'b1;
                // sense catches up only once a transfer completes
                den_rep <= den_sel;
            end
        end
    end
    assign reserved = cif.reserved;
    // ------------------------------------------------------------------------
    // read data register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
            if (apb_rd && !pready) begin
                case (paddr)
                    `TDRC_ADDR_CTRL: prdata <= {25'h0, fmt_match, cart_ok, parity_err, 2'h0,
                        at_bot, hicap};
                    `TDRC_ADDR_CMD: prdata <= {13'h0, init_id, byte1, opcode};
                    `TDRC_ADDR_CMD2: prdata <= {23'h0, bad_field, den_param};
                    `TDRC_ADDR_STAT: prdata <= {22'h0, cif.target, cif.owner, cif.reserved,
                        pending_attn, explicit_mode, busy};
                    `TDRC_ADDR_RESULT: prdata <= {20'h0, sense, status};
                    // descriptor: density, zero block count
                    `TDRC_ADDR_DESC0: prdata <= {`TDRC_BLOCK_COUNT, den_rep};
                    // descriptor: 512 byte fixed length
                    `TDRC_ADDR_DESC1: prdata <= {8'h00, `TDRC_BLOCK_LEN};
                    default: begin
                        prdata <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    sequence s_ms_good;
        ok_exec && is_ms;
    endsequence
    chk_sense_hold: assert property (@(posedge sys_clk) disable iff (!rst_n_s)
        (s_ms_good and !bdr) |=> den_rep == $past(den_rep))
        else $error("mode sense changed before transfer");
    chk_parity_hw: assert property (@(posedge sys_clk) disable iff (!rst_n_s)
        (state == tdrc_pkg::TDRC_EXEC && parity_err && !cif.blocked) |=> sense == `TDRC_SK_HWERR)
        else $error("parity error without hardware error");
    chk_conflict: assert property (@(posedge sys_clk) disable iff (!rst_n_s)
        (state == tdrc_pkg::TDRC_EXEC && cif.blocked) |=> status == `TDRC_ST_CONFLICT)
        else $error("excluded initiator not refused");
    chk_xfer_mode: assert property (@(posedge sys_clk) disable iff (!rst_n_s)
        (ok_exec && (is_rd || is_wr) && !bdr) |=> explicit_mode)
        else $error("transfer left implicit mode");
    chk_ms_bot: assert property (@(posedge sys_clk) disable iff (!rst_n_s)
        (state == tdrc_pkg::TDRC_EXEC && is_ms && !at_bot && !cif.blocked && !parity_err
        && !pending_attn) |=> sense == `TDRC_SK_ILLEGAL)
        else $error("mode select away from tape start accepted");
endmodule

// [tdrc_params.svh]
// constants, field positions and codes for the tape density and reservation command block
// What this block does
// - read, write or nonzero density enters explicit mode
// - explicit read on other format: blank check
// - explicit unsupported cartridge write: check, write protect
// - high capacity write density 04h/05h: illegal request
// - mode report keeps old density until transfer
// - descriptor block count bytes read zero
// - descriptor block length reads 512 bytes
// - good mode select keeps mode until reset
// - parity error gives hardware error sense
// - mode select bad bit, code, position: illegal
// - cartridge change or reset: unit attention
// - reserve unit reserves for requester or delegate
// - owner reserve replaces reservation without error
// - owner release returns to unreserved state
// - bus device reset or reset clears reservation
// - excluded initiator gets reservation conflict
// - release and owner reserve exempt from conflict
// - reserve block six bytes, opcode 16h layout
// - byte 1 bit 4 is on behalf flag
// - delegate id bits 3:1 valid only with flag
// - foreign release ignored, still good status
`ifndef TDRC_PARAMS_SVH
`define TDRC_PARAMS_SVH
// ----------------------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------------------
`define TDRC_ADDR_CTRL 12'h000
`define TDRC_ADDR_CMD 12'h004
`define TDRC_ADDR_CMD2 12'h008
`define TDRC_ADDR_STAT 12'h00C
`define TDRC_ADDR_RESULT 12'h010
`define TDRC_ADDR_DESC0 12'h014
`define TDRC_ADDR_DESC1 12'h018
// ----------------------------------------------------------------------------
// command codes and status values
// ----------------------------------------------------------------------------
`define TDRC_OP_RESERVE 8'h16
`define TDRC_OP_RELEASE 8'h17
`define TDRC_OP_MODESEL 8'h15
`define TDRC_OP_MODESENSE 8'h1A
`define TDRC_OP_READ 8'h08
`define TDRC_OP_WRITE 8'h0A
`define TDRC_ST_GOOD 8'h00
`define TDRC_ST_CHECK 8'h02
`define TDRC_ST_CONFLICT 8'h18
`define TDRC_SK_NONE 4'h0
`define TDRC_SK_HWERR 4'h4
`define TDRC_SK_ILLEGAL 4'h5
`define TDRC_SK_ATTN 4'h6
`define TDRC_SK_PROTECT 4'h7
`define TDRC_SK_BLANK 4'h8
`define TDRC_DEN_IMPLICIT 8'h00
`define TDRC_DEN_LOW_A 8'h04
`define TDRC_DEN_LOW_B 8'h05
`define TDRC_DEN_OLD_A 8'h0F
`define TDRC_DEN_OLD_B 8'h10
// ----------------------------------------------------------------------------
// field positions and fixed descriptor values
// ----------------------------------------------------------------------------
`define TDRC_B1_FLAG 4
`define TDRC_B1_ID_HI 3
`define TDRC_B1_ID_LO 1
`define TDRC_BLOCK_COUNT 24'h000000
`define TDRC_BLOCK_LEN 24'h000200
`define TDRC_CTRL_HICAP 0
`define TDRC_CTRL_BOT 1
`define TDRC_CTRL_CHANGE 2
`define TDRC_CTRL_BDR 3
`define TDRC_CTRL_PARITY 4
`define TDRC_CTRL_CART 5
`define TDRC_CTRL_FMT 6
`endif

// [tdrc_pkg.sv]
// types shared by the tape density and reservation command block
package tdrc_pkg;
    // command sequencer states
    typedef enum logic [1:0] {
        TDRC_IDLE,
        TDRC_EXEC,
        TDRC_DONE
    } tdrc_state_t;
endpackage

// [tdrc_cmd_if.sv]
// carrier between the command sequencer and the reservation keeper
`timescale 1ns/1ps
interface tdrc_cmd_if;
    logic go;         // one-cycle command strobe
    logic [2:0] init_id; // initiator of the command
    logic [7:0] opcode;  // command operation code
    logic [7:0] byte1;   // command byte 1
    logic blocked;    // reservation conflict for this command
    logic reserved;   // reservation held
    logic [2:0] owner;   // reservation owner
    logic [2:0] target;  // initiator allowed to use the unit
    modport seq (output go, init_id, opcode, byte1, input blocked, reserved, owner, target);
    modport keep (input go, init_id, opcode, byte1, output blocked, reserved, owner, target);
endinterface

// [tdrc_reserve.sv]
// reservation keeper: owner, delegate and conflict decision
`timescale 1ns/1ps
`include "tdrc_params.svh"
module tdrc_reserve (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_reset,
    // command carrier
    tdrc_cmd_if.keep c
);
    logic held;          // reservation present
    logic [2:0] owner_id;   // initiator that reserved
    logic [2:0] target_id;  // initiator in control
    logic is_res;
    logic is_rel;
    logic from_owner;
    logic flag;
    assign is_res = (c.opcode == `TDRC_OP_RESERVE);
    assign is_rel = (c.opcode == `TDRC_OP_RELEASE);
    assign from_owner = (c.init_id == owner_id);
    assign flag = c.byte1[`TDRC_B1_FLAG];
    // conflict decision, combinational so the sequencer sees it with go
    always_comb begin
        c.blocked = 1'b0;
        // excluded initiators are refused, release and owner reserve pass
        if (held && (c.init_id != target_id) && !is_rel && !(is_res && from_owner)) begin
            c.blocked = 1'b1;
        end
    end
    // ------------------------------------------------------------------------
    // reservation state
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held <= 1'b0;
            owner_id <= 3'h0;
            target_id <= 3'h0;
        end else if (bus_reset) begin
            // bus device reset from any initiator drops everything
            held <= 1'b0;
            owner_id <= 3'h0;
            target_id <= 3'h0;
        end else if (c.go && !c.blocked) begin
            if (is_res) begin
                // new or replacing reservation, never an error
                held <= 1'b1;
                owner_id <= c.init_id;
                // delegate id only counts with the flag set
                target_id <= flag ? c.byte1[`TDRC_B1_ID_HI:`TDRC_B1_ID_LO] : c.init_id;
            end else if (is_rel && held && from_owner) begin
                // a foreign release changes nothing
                held <= 1'b0;
                owner_id <= 3'h0;
                target_id <= 3'h0;
            end
        end
    end
    assign c.reserved = held;
    assign c.owner = owner_id;
    assign c.target = target_id;
    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    chk_bdr_clears: assert property (@(posedge clk) disable iff (!rst_n)
        bus_reset |=> !held) else $error("bus device reset left reservation");
    chk_owner_release: assert property (@(posedge clk) disable iff (!rst_n)
        (c.go && is_rel && held && from_owner && !bus_reset) |=> !held)
        else $error("owner release did not free unit");
    chk_foreign_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (c.go && is_rel && held && !from_owner && !bus_reset) |=> held && $stable(owner_id))
        else $error("foreign release changed reservation");
    chk_res_take: assert property (@(posedge clk) disable iff (!rst_n)
        (c.go && is_res && !c.blocked && !bus_reset) |=> held && owner_id == $past(c.init_id))
        else $error("reserve did not record owner");
endmodule

// [tdrc_initiator.sv]
// initiator model: drives command traffic into the register bus as an APB master
`timescale 1ns/1ps
`include "tdrc_params.svh"
module tdrc_initiator (
    // clock
    input wire logic clk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ------------------------------------------------------------
    // bus idle at time zero
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // one transfer; request held until pready seen high at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no fixed latency assumed; the bench timeout cuts a hang
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // six byte command block squeezed into the launch word
    task automatic send(input logic [7:0] op, input logic fl, input logic [2:0] did,
                        input logic [2:0] id);
        logic [7:0] b1;
        logic [31:0] rd;
        logic err;
        b1 = {3'b000, fl, did, 1'b0};
        xfer(1'b1, `TDRC_ADDR_CMD, {13'h0000, id, b1, op}, rd, err);
    endtask
endmodule

// [tape_density_and_reservation_cmds_bench.sv]
// self-checking bench for the tape density and reservation command block
`timescale 1ns/1ps
`include "tdrc_params.svh"
module tape_density_and_reservation_cmds_bench;
    // ------------------------------------------------------------
    // clock, reset and bus wires
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, explicit_mode, reserved;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic e;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    // one command: control bits, mode param, opcode, flag, delegate, id, expected
    typedef struct {
        logic [6:0] ctrl; logic [8:0] den; logic [7:0] op; logic fl; logic [2:0] did;
        logic [2:0] id; logic [7:0] st; logic [3:0] sk; logic res;
    } tdrc_row_t;
    tdrc_row_t rows [22] = '{
        '{7'h62, 9'h000, 8'h1A, 0, 0, 0, 8'h02, 4'h6, 0},
        '{7'h62, 9'h010, 8'h15, 0, 0, 0, 8'h00, 4'h0, 0},
        '{7'h60, 9'h010, 8'h15, 0, 0, 0, 8'h02, 4'h5, 0},
        '{7'h62, 9'h110, 8'h15, 0, 0, 0, 8'h02, 4'h5, 0},
        '{7'h72, 9'h000, 8'h08, 0, 0, 0, 8'h02, 4'h4, 0},
        '{7'h22, 9'h000, 8'h08, 0, 0, 0, 8'h02, 4'h8, 0},
        '{7'h02, 9'h000, 8'h0A, 0, 0, 0, 8'h02, 4'h7, 0},
        '{7'h62, 9'h000, 8'h08, 0, 0, 0, 8'h00, 4'h0, 0},
        '{7'h63, 9'h004, 8'h15, 0, 0, 0, 8'h00, 4'h0, 0},
        '{7'h63, 9'h000, 8'h0A, 0, 0, 0, 8'h02, 4'h5, 0},
        '{7'h62, 9'h000, 8'h16, 0, 0, 1, 8'h00, 4'h0, 1},
        '{7'h62, 9'h000, 8'h1A, 0, 0, 2, 8'h18, 4'h0, 1},
        '{7'h62, 9'h000, 8'h17, 0, 0, 2, 8'h00, 4'h0, 1},
        '{7'h62, 9'h000, 8'h16, 0, 0, 1, 8'h00, 4'h0, 1},
        '{7'h62, 9'h000, 8'h16, 1, 3, 1, 8'h00, 4'h0, 1},
        '{7'h62, 9'h000, 8'h1A, 0, 0, 3, 8'h00, 4'h0, 1},
        '{7'h62, 9'h000, 8'h1A, 0, 0, 1, 8'h18, 4'h0, 1},
        '{7'h62, 9'h000, 8'h17, 0, 0, 1, 8'h00, 4'h0, 0},
        '{7'h62, 9'h000, 8'h16, 0, 3, 4, 8'h00, 4'h0, 1},
        '{7'h62, 9'h000, 8'h16, 0, 0, 4, 8'h00, 4'h0, 1},
        '{7'h62, 9'h000, 8'h1A, 0, 0, 5, 8'h18, 4'h0, 1},
        '{7'h6A, 9'h000, 8'h1A, 0, 0, 5, 8'h02, 4'h6, 0}
    };

    // ------------------------------------------------------------
    // design, initiator model and clock
    // ------------------------------------------------------------
    tdrc_top i_tdrc_top (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .explicit_mode(explicit_mode), .reserved(reserved));
    tdrc_initiator i_tdrc_initiator (.clk(sys_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    always #2 sys_clk = ~sys_clk;

    // hang guard: well above the fewer than a thousand cycles the run needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_tdrc_initiator.xfer(1'b1, a, d, v, e);
    endtask
    // launch one command and wait for busy to drop
    task automatic run(input tdrc_row_t r);
        wr(`TDRC_ADDR_CTRL, {25'h0, r.ctrl});
        wr(`TDRC_ADDR_CMD2, {23'h0, r.den});
        i_tdrc_initiator.send(r.op, r.fl, r.did, r.id);
        v = 32'h00000001;
        while (v[0] !== 1'b0) i_tdrc_initiator.xfer(1'b0, `TDRC_ADDR_STAT, 32'h0, v, e);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        foreach (rows[i]) begin
            run(rows[i]);
            i_tdrc_initiator.xfer(1'b0, `TDRC_ADDR_RESULT, 32'h0, v, e);
            chk({20'h0, v[11:0]}, {20'h0, rows[i].sk, rows[i].st});
            chk({31'h0, reserved}, {31'h0, rows[i].res});
            if (i == 9) begin
                // old density still reported after the refused write
                i_tdrc_initiator.xfer(1'b0, `TDRC_ADDR_DESC0, 32'h0, v, e);
                chk(v, 32'h00000010);
            end
        end
        // bus device reset dropped the selected density
        i_tdrc_initiator.xfer(1'b0, `TDRC_ADDR_DESC0, 32'h0, v, e);
        chk(v, 32'h00000000);
        i_tdrc_initiator.xfer(1'b0, `TDRC_ADDR_DESC1, 32'h0, v, e);
        chk(v, 32'h00000200);
        i_tdrc_initiator.xfer(1'b0, 12'hFFC, 32'h0, v, e);
        chk({31'h0, e}, 32'h00000001);
        // reset in mid-run while reserved; first reserve takes the unit, second is an owner reserve
        run(rows[10]);
        run(rows[10]);
        chk({31'h0, reserved}, 32'h00000001);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({30'h0, explicit_mode, reserved}, 32'h00000000);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        i_tdrc_initiator.xfer(1'b0, `TDRC_ADDR_STAT, 32'h0, v, e);
        chk({29'h0, v[3:2], 1'b0}, 32'h00000002);
        run(rows[0]);
        run(rows[7]);
        chk({31'h0, explicit_mode}, 32'h00000001);
        tally_and_finish();
    end
endmodule
